// [logic/bat_pkg.sv]
// Constants and types for the biphase audio transmitter
`default_nettype none
package bat_pkg;
  // APB register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_CS_LO = 8'h08;
  localparam logic [7:0] A_CS_HI = 8'h0C;
  localparam logic [13:0] CTRL_RST = 14'h0000;
  localparam int CTRL_W = 14;
  // Control register fields
  localparam int CT_OPR = 0;
  localparam int CT_MUTE = 1;
  localparam int CT_CKSEL = 2;
  localparam int CT_LRP = 3;
  localparam int CT_DFS = 4;
  localparam int CT_SRC = 5;
  localparam int CT_VALIDITY_PIN_ENABLE = 6;
  localparam int CT_VALIDITY_HOST_WRITE_MODE = 7;
  localparam int CT_USER_BIT_PIN_ENABLE = 8;
  localparam int CT_VHOST = 9;
  localparam int CT_MONO = 10;
  localparam int CT_PBS = 12;
  // Status register fields
  localparam int ST_RUN = 0;
  localparam int ST_FNEN = 1;
  localparam int ST_MCK = 2;
  localparam int ST_FRM = 8;
  // Synchroniser lanes
  localparam int SY_MCK = 0;
  localparam int SY_BCK = 1;
  localparam int SY_LRCK = 2;
  localparam int SY_DATA = 3;
  localparam int SY_AUX = 4;
  localparam int SY_VPIN = 5;
  localparam int SY_UPIN = 6;
  localparam int SY_STRAP = 7;
  // Modes, patterns, counts
  localparam logic [1:0] MONO_LEFT = 2'h1;
  localparam logic [1:0] MONO_RIGHT = 2'h2;
  localparam logic [1:0] PBS_TX = 2'h1;
  localparam logic [7:0] PRE_B = 8'hE8;
  localparam logic [7:0] PRE_M = 8'hE2;
  localparam logic [7:0] PRE_W = 8'hE4;
  localparam logic [7:0] BLK_LAST = 8'hBF;
  localparam logic [7:0] CS_BITS = 8'h30;
  localparam logic [6:0] HC_LAST = 7'h7F;
  localparam logic [4:0] I2S_LAST = 5'h17;
  localparam logic [1:0] STRAP_WAIT = 2'h3;
  localparam int W_V = 28;
  typedef enum logic [1:0] {
    BAT_STOP = 2'b00,
    BAT_ARM = 2'b01,
    BAT_RUN = 2'b10
  } bat_state_e;
endpackage : bat_pkg
`default_nettype wire

// [logic/bat_top.sv]
// Biphase audio transmitter with APB register slave
//
// Operation
// - Transmitter idles after reset; starts only when operate bit is set.
// - Source gives master, bit, frame clocks and data; output is biphase.
// - Host bit selects master clock ratio 256fs or 128fs; the bit is only held, the coder runs off bit clock edges.
// - Host bit picks which frame clock level marks the left channel.
// - Handles 32 to 192 kHz, 4 to 25 MHz lines, 24-bit words.
// - Input format is I2S by default; host bit selects right-justified.
// - Host writes the first 48 channel status bits of each block.
// - Output held low when operate is clear or mute is set.
// - Validity pin, when enabled, supplies the flag: 1 means error.
// - Host may write validity in its mode; pin value wins.
// - User bit pin, when enabled, supplies user data per subframe.
// - Block sync from preamble B frames user data, driven on sync pin.
// - Auxiliary input selected: modulated result on output and loopback.
// - Two-bit field selects mono: one channel at half rate.
// - Mono keeps biphase coding; preambles need not match channels.
// - Mono channel status advances at the reduced output rate.
// - Block sync is high exactly while status bit 0 goes out.
// - Sync select routes only one sync source to the shared pin.
// - Transmitter works only when interrupt pin strapped low.
//
// Chosen here: the address map and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module bat_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output var logic [31:0] prdata,
  output var logic pready,
  output var logic pslverr,
  input wire logic transmit_master_clock,
  input wire logic transmit_bit_clock,
  input wire logic transmit_frame_clock,
  input wire logic transmit_data,
  input wire logic auxiliary_serial_audio_in,
  input wire logic validity_input_pin,
  input wire logic user_bit_input_pin,
  input wire logic interrupt_strap_pin,
  output var logic biphase_output,
  output var logic loopback_receive_output,
  output var logic block_sync_output_pin
);
  logic [7:0] pins_in;
  logic [7:0] meta_ff;
  logic [7:0] sync_ff;
  logic bclk_d_ff;
  logic lrck_d_ff;
  logic mck_d_ff;
  logic [13:0] ctrl_ff;
  logic [47:0] cs_ff;
  logic [31:0] nxt_rdata;
  logic nxt_err;
  logic acc;
  logic [1:0] strap_cnt_ff;
  logic strap_done_ff;
  logic tx_fn_en_ff;
  logic mck_seen_ff;
  bat_pkg::bat_state_e state_ff;
  bat_pkg::bat_state_e nxt_state;
  logic go;
  logic running;
  logic bclk_rise;
  logic bclk_edge;
  logic lr_edge;
  logic din;
  logic [23:0] sh_ff;
  logic lrp_ff;
  logic [4:0] bcnt_ff;
  logic chg;
  logic cap;
  logic [23:0] cap_word;
  logic [23:0] left_ff;
  logic [23:0] right_ff;
  logic mono;
  logic div_ff;
  logic hstep;
  logic [6:0] hcnt_ff;
  logic [7:0] frame_ff;
  logic [31:0] word_ff;
  logic [31:0] nxt_word;
  logic [7:0] pre_ff;
  logic [7:0] pre_sel;
  logic lvl_ff;
  logic use_right;
  logic [23:0] smp;
  logic v_bit;
  logic u_bit;
  logic c_bit;
  logic ctl_opr;
  logic ctl_mute;
  logic ctl_lrp;
  logic ctl_dfs;
  logic ctl_src;
  logic ctl_validity_pin_enable;
  logic ctl_validity_host_write_mode;
  logic ctl_user_bit_pin_enable;
  logic ctl_vhost;
  logic [1:0] ctl_mono;
  logic [1:0] ctl_pbs;

  // Control fields
  assign ctl_opr = ctrl_ff[bat_pkg::CT_OPR];
  assign ctl_mute = ctrl_ff[bat_pkg::CT_MUTE];
  assign ctl_lrp = ctrl_ff[bat_pkg::CT_LRP];
  assign ctl_dfs = ctrl_ff[bat_pkg::CT_DFS];
  assign ctl_src = ctrl_ff[bat_pkg::CT_SRC];
  assign ctl_validity_pin_enable = ctrl_ff[bat_pkg::CT_VALIDITY_PIN_ENABLE];
  assign ctl_validity_host_write_mode = ctrl_ff[bat_pkg::CT_VALIDITY_HOST_WRITE_MODE];
  assign ctl_user_bit_pin_enable = ctrl_ff[bat_pkg::CT_USER_BIT_PIN_ENABLE];
  assign ctl_vhost = ctrl_ff[bat_pkg::CT_VHOST];
  assign ctl_mono = ctrl_ff[bat_pkg::CT_MONO +: 2];
  assign ctl_pbs = ctrl_ff[bat_pkg::CT_PBS +: 2];

  // Every pin from the source side crosses two flops first
  assign pins_in = {interrupt_strap_pin, user_bit_input_pin,
    validity_input_pin, auxiliary_serial_audio_in, transmit_data,
    transmit_frame_clock, transmit_bit_clock, transmit_master_clock};
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_ff <= 8'h00;
      sync_ff <= 8'h00;
    end
    else
    begin
      meta_ff <= pins_in;
      sync_ff <= meta_ff;
    end
  end

  // Third stage only for edge detection of the link clocks
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bclk_d_ff <= 1'b0;
      lrck_d_ff <= 1'b0;
      mck_d_ff <= 1'b0;
    end
    else
    begin
      bclk_d_ff <= sync_ff[bat_pkg::SY_BCK];
      lrck_d_ff <= sync_ff[bat_pkg::SY_LRCK];
      mck_d_ff <= sync_ff[bat_pkg::SY_MCK];
    end
  end
  assign bclk_rise = sync_ff[bat_pkg::SY_BCK] & ~bclk_d_ff;
  assign bclk_edge = sync_ff[bat_pkg::SY_BCK] ^ bclk_d_ff;
  assign lr_edge = sync_ff[bat_pkg::SY_LRCK] ^ lrck_d_ff;

  // APB slave: one wait state so read data leaves a flop
  assign acc = psel & penable;
  always_comb
  begin
    nxt_rdata = 32'h0000_0000;
    nxt_err = 1'b0;
    case (paddr)
      bat_pkg::A_CTRL: nxt_rdata[13:0] = ctrl_ff;
      bat_pkg::A_STAT:
      begin
        nxt_rdata[bat_pkg::ST_RUN] = running;
        nxt_rdata[bat_pkg::ST_FNEN] = tx_fn_en_ff;
        nxt_rdata[bat_pkg::ST_MCK] = mck_seen_ff;
        nxt_rdata[bat_pkg::ST_FRM +: 8] = frame_ff;
      end
      bat_pkg::A_CS_LO: nxt_rdata = cs_ff[31:0];
      bat_pkg::A_CS_HI: nxt_rdata[15:0] = cs_ff[47:32];
      default: nxt_err = 1'b1;
    endcase
  end

  // Answer flops; pready pulses for one access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= acc & ~pready;
      pslverr <= acc & ~pready & nxt_err;
      prdata <= (acc & ~pready & ~pwrite) ? nxt_rdata : 32'h0000_0000;
    end
  end

  // Register writes land at the completing edge only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_ff <= bat_pkg::CTRL_RST; // Operate clear: stays stopped
      cs_ff <= 48'h0000_0000_0000;
    end
    else if (acc & pready & pwrite)
    begin
      case (paddr)
        bat_pkg::A_CTRL: ctrl_ff <= pwdata[13:0]; // Ratio bit held
        bat_pkg::A_CS_LO: cs_ff[31:0] <= pwdata;
        bat_pkg::A_CS_HI: cs_ff[47:32] <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // Strap caught a few cycles after reset, once synchronised
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      strap_cnt_ff <= 2'h0;
      strap_done_ff <= 1'b0;
      tx_fn_en_ff <= 1'b0;
    end
    else if (!strap_done_ff)
    begin
      if (strap_cnt_ff == bat_pkg::STRAP_WAIT)
      begin
        strap_done_ff <= 1'b1;
        tx_fn_en_ff <= ~sync_ff[bat_pkg::SY_STRAP]; // Low strap
      end
      else
        strap_cnt_ff <= strap_cnt_ff + 2'h1;
    end
  end

  // Master clock activity; the ratio cannot be measured at this rate
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mck_seen_ff <= 1'b0;
    else if (sync_ff[bat_pkg::SY_MCK] ^ mck_d_ff)
      mck_seen_ff <= 1'b1;
    else if (lr_edge)
      mck_seen_ff <= 1'b0;
  end

  // Start and stop sequencing; start aligned to a left-channel frame edge, stop at once
  assign go = ctl_opr & tx_fn_en_ff;
  assign running = (state_ff == bat_pkg::BAT_RUN);
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      bat_pkg::BAT_STOP:
        if (go)
          nxt_state = bat_pkg::BAT_ARM;
      bat_pkg::BAT_ARM:
        if (!go)
          nxt_state = bat_pkg::BAT_STOP;
        else if (lr_edge && sync_ff[bat_pkg::SY_LRCK] == ctl_lrp)
          nxt_state = bat_pkg::BAT_RUN; // Left level per polarity
      bat_pkg::BAT_RUN:
        if (!go)
          nxt_state = bat_pkg::BAT_STOP;
      default: nxt_state = bat_pkg::BAT_STOP;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_ff <= bat_pkg::BAT_STOP;
    else
      state_ff <= nxt_state;
  end

  // Serial input shifter on bit clock rising edges
  assign din = ctl_src ? sync_ff[bat_pkg::SY_AUX]
                       : sync_ff[bat_pkg::SY_DATA];
  assign chg = sync_ff[bat_pkg::SY_LRCK] != lrp_ff;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sh_ff <= 24'h00_0000;
      lrp_ff <= 1'b0;
      bcnt_ff <= 5'h00;
    end
    else if (bclk_rise)
    begin
      sh_ff <= {sh_ff[22:0], din};
      if (chg)
      begin
        lrp_ff <= sync_ff[bat_pkg::SY_LRCK];
        bcnt_ff <= 5'h00;
      end
      else if (bcnt_ff != 5'h1F)
        bcnt_ff <= bcnt_ff + 5'h01;
    end
  end

  // Right-justified takes the last 24 bits at the frame edge;
  // I2S takes 24 bits after the one-bit delay
  assign cap = bclk_rise &
    (ctl_dfs ? chg : (~chg & bcnt_ff == bat_pkg::I2S_LAST));
  assign cap_word = ctl_dfs ? sh_ff : {sh_ff[22:0], din};
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      left_ff <= 24'h00_0000;
      right_ff <= 24'h00_0000;
    end
    else if (cap)
    begin
      if (lrp_ff == ctl_lrp)
        left_ff <= cap_word;
      else
        right_ff <= cap_word;
    end
  end

  // Mono halves the half-cell rate, so each subframe lasts one
  // input frame and carries one sample of the chosen channel
  assign mono = (ctl_mono == bat_pkg::MONO_LEFT) |
                (ctl_mono == bat_pkg::MONO_RIGHT);
  assign hstep = running & bclk_edge & (~mono | div_ff);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_ff <= 1'b0;
    else if (!running)
      div_ff <= 1'b0;
    else if (bclk_edge)
      div_ff <= ~div_ff;
  end

  // Subframe contents chosen at half-cell zero
  assign use_right = mono ? (ctl_mono == bat_pkg::MONO_RIGHT)
                          : hcnt_ff[6];
  assign smp = use_right ? right_ff : left_ff;
  // Pin value has priority over the host value
  assign v_bit = ctl_validity_pin_enable ? sync_ff[bat_pkg::SY_VPIN]
                           : (ctl_validity_host_write_mode & ctl_vhost);
  assign u_bit = ctl_user_bit_pin_enable & sync_ff[bat_pkg::SY_UPIN];
  assign c_bit = (frame_ff < bat_pkg::CS_BITS) ?
                 cs_ff[frame_ff[5:0]] : 1'b0;
  always_comb
  begin
    nxt_word = {1'b0, c_bit, u_bit, v_bit, smp, 4'h0};
    nxt_word[31] = ^nxt_word[30:4]; // Even parity keeps level cycle
    if (hcnt_ff[6])
      pre_sel = bat_pkg::PRE_W;
    else if (frame_ff == 8'h00)
      pre_sel = bat_pkg::PRE_B;
    else
      pre_sel = bat_pkg::PRE_M;
  end

  // Half-cell counter and block frame counter; status advances
  // per output frame, which is slower in mono
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hcnt_ff <= 7'h00;
      frame_ff <= 8'h00;
    end
    else if (!running)
    begin
      hcnt_ff <= 7'h00;
      frame_ff <= 8'h00;
    end
    else if (hstep)
    begin
      hcnt_ff <= hcnt_ff + 7'h01;
      if (hcnt_ff == bat_pkg::HC_LAST)
        frame_ff <= (frame_ff == bat_pkg::BLK_LAST) ? 8'h00
                    : frame_ff + 8'h01;
    end
  end

  // Biphase mark coder: preamble cells, then a transition at each
  // cell start and mid-cell for a one
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lvl_ff <= 1'b0;
      word_ff <= 32'h0000_0000;
      pre_ff <= 8'h00;
    end
    else if (!running)
      lvl_ff <= 1'b0;
    else if (hstep)
    begin
      if (hcnt_ff[5:0] == 6'h00)
      begin
        word_ff <= nxt_word;
        pre_ff <= pre_sel ^ {8{lvl_ff}};
        lvl_ff <= pre_sel[7] ^ lvl_ff;
      end
      else if (hcnt_ff[5:3] == 3'h0)
        lvl_ff <= pre_ff[3'h7 - hcnt_ff[2:0]];
      else if (!hcnt_ff[0])
        lvl_ff <= ~lvl_ff;
      else
        lvl_ff <= lvl_ff ^ word_ff[hcnt_ff[5:1]];
    end
  end

  // Output pins; held low when stopped, biphase and loopback also when muted
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      biphase_output <= 1'b0;
      loopback_receive_output <= 1'b0;
      block_sync_output_pin <= 1'b0;
    end
    else
    begin
      biphase_output <= ctl_opr & ~ctl_mute & running & lvl_ff;
      loopback_receive_output <= ctl_src & ctl_opr & ~ctl_mute &
                                 running & lvl_ff;
      block_sync_output_pin <= running & (ctl_pbs == bat_pkg::PBS_TX)
                               & (frame_ff == 8'h00);
    end
  end

  // Checks on the transmitter's own behaviour
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  mute_low_a: assert property (
    (!ctl_opr || ctl_mute) |=> !biphase_output)
    else $error("output not low while stopped or muted");
  stop_idle_a: assert property (
    (!go && state_ff != bat_pkg::BAT_STOP)
    |=> state_ff == bat_pkg::BAT_STOP)
    else $error("transmitter did not stop");
  strap_gate_a: assert property (
    (strap_done_ff && !tx_fn_en_ff) |=> state_ff != bat_pkg::BAT_RUN)
    else $error("ran without low strap");
  sync_pin_a: assert property (
    block_sync_output_pin == $past(running &&
      ctl_pbs == bat_pkg::PBS_TX && frame_ff == 8'h00))
    else $error("block sync wrong");
  loop_out_a: assert property (
    loopback_receive_output |-> biphase_output && $past(ctl_src))
    else $error("loopback without auxiliary source");
  cs_write_a: assert property (
    (acc && pready && pwrite && paddr == bat_pkg::A_CS_LO)
    |=> cs_ff[31:0] == $past(pwdata))
    else $error("status bits not written");
  vpin_pick_a: assert property (
    (hstep && hcnt_ff[5:0] == 6'h00 && ctl_validity_pin_enable)
    |=> word_ff[bat_pkg::W_V] == $past(sync_ff[bat_pkg::SY_VPIN]))
    else $error("validity pin not used");
  vhost_pick_a: assert property (
    (hstep && hcnt_ff[5:0] == 6'h00 && !ctl_validity_pin_enable && ctl_validity_host_write_mode)
    |=> word_ff[bat_pkg::W_V] == $past(ctl_vhost))
    else $error("host validity not used");
  mono_left_a: assert property (
    (hstep && hcnt_ff[5:0] == 6'h00 && ctl_mono == bat_pkg::MONO_LEFT)
    |=> word_ff[27:4] == $past(left_ff))
    else $error("mono did not take left sample");
  pre_b_a: assert property (
    (hstep && hcnt_ff == 7'h00 && frame_ff == 8'h00)
    |=> pre_ff == ($past(lvl_ff) ? ~bat_pkg::PRE_B : bat_pkg::PRE_B))
    else $error("block start without preamble B");

  cover property (running && frame_ff == bat_pkg::BLK_LAST);
  cover property (block_sync_output_pin);
  cover property (hstep && mono);
  cover property (loopback_receive_output);
endmodule : bat_top
`default_nettype wire

// [tb/bat_source_model.sv]
// Serial audio source model: master, bit and frame clocks plus sample data
`timescale 1ns/1ns
`default_nettype none
module bat_source_model (
  input wire logic half_rate,
  input wire logic left_lvl,
  input wire logic right_just,
  input wire logic [23:0] smp_l,
  input wire logic [23:0] smp_r,
  input wire logic [23:0] aux_l,
  input wire logic [23:0] aux_r,
  output var logic mck,
  output var logic bck,
  output var logic lrck,
  output var logic sdata,
  output var logic adata
);
  int k;
  int b;

  // Word bit for the current slot; unused slots toggle so nothing looks held
  function automatic logic slot_bit(input logic [23:0] l,
    input logic [23:0] r);
    int s;
    logic [23:0] v;
    s = b % 32;
    v = (b < 32) ? l : r;
    if (right_just)
      return (s >= 8) ? v[31 - s] : b[0];
    return (s >= 1 && s <= 24) ? v[24 - s] : b[0];
  endfunction : slot_bit

  // Clocks run free on a 40 ns tick offset from pclk, 320 ns bit clock
  initial
  begin
    k = 0;
    b = 0;
    mck = 1'b0;
    bck = 1'b0;
    lrck = 1'b0;
    sdata = 1'b0;
    adata = 1'b0;
    #13;
    forever
    begin
      mck <= half_rate ? (k % 4 >= 2) : (k % 2 == 0);
      bck <= (k >= 4);
      if (k == 0)
      begin
        // Frame clock and 24-bit words move on bit clock falls
        lrck <= (b < 32) ? left_lvl : ~left_lvl;
        sdata <= slot_bit(smp_l, smp_r);
        adata <= slot_bit(aux_l, aux_r);
      end
      #40;
      k = (k + 1) % 8;
      if (k == 0)
        b = (b + 1) % 64;
    end
  end
endmodule : bat_source_model
`default_nettype wire

// [tb/biphase_audio_transmitter_test.sv]
// Self-checking bench for the biphase audio transmitter
`timescale 1ns/1ns
`default_nettype none
module biphase_audio_transmitter_test;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, seed, r;
  logic mck, bck, lrck, sd, ad, vpin, upin, strap, bo, lb, bs;
  logic ratio, pol, rj, v, u;
  logic [23:0] sl, sr, al, ar, el, er;
  logic [13:0] c;
  logic [1:0] m;
  logic hc [256];
  logic hl [256];
  logic hs [256];
  logic [32:0] expq [$];
  logic [13:0] cfg [5] = '{14'h1141, 14'h029D, 14'h03E1, 14'h1441, 14'h0919};
  int mismatches, cmp_count, n;

  bat_top u_bat_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .transmit_master_clock(mck), .transmit_bit_clock(bck),
    .transmit_frame_clock(lrck), .transmit_data(sd),
    .auxiliary_serial_audio_in(ad), .validity_input_pin(vpin),
    .user_bit_input_pin(upin), .interrupt_strap_pin(strap),
    .biphase_output(bo), .loopback_receive_output(lb),
    .block_sync_output_pin(bs));

  bat_source_model u_bat_source_model (.half_rate(ratio), .left_lvl(pol),
    .right_just(rj), .smp_l(sl), .smp_r(sr), .aux_l(al), .aux_r(ar),
    .mck(mck), .bck(bck), .lrck(lrck), .sdata(sd), .adata(ad));

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd

  task automatic chk(input string nm, input logic [32:0] e,
    input logic [32:0] g);
    cmp_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic conclude();
    $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude

  // One APB transfer; the expected {pslverr, data} goes to the queue
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, input logic [32:0] e);
    int k;
    @(posedge pclk);
    expq.push_back(e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a; // Host settings go through the mapped bus
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    chk("apb wait", 0, k >= 50);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Stream must sit low for the whole span
  task automatic quiet(input int t);
    int q;
    q = 0;
    repeat (t)
    begin
      @(posedge pclk);
      q += (bo !== 1'b0);
    end
    chk("held low", 0, q);
  endtask : quiet

  // Each half-cell is read two pclk after the first pin edge inside it, which ends it at step 1, before
  // the coder lets the next one out; the start waits on the output itself,
  // since polling on pclk would miss the pin edge right after it
  task automatic grab(input int step);
    int k;
    k = 0;
    while (bo !== 1'b1 && k < 3000)
    begin
      @(posedge pclk or posedge bo);
      k++;
    end
    chk("start", 1, k < 3000);
    for (int i = 0; i < 256; i++)
    begin
      @(bck);
      repeat (2) @(posedge pclk);
      hc[i] = bo;
      hl[i] = lb;
      hs[i] = bs;
      repeat (step - 1) @(bck);
    end
  endtask : grab

  // Decode one subframe; full selects the payload comparison
  task automatic sub_check(input int s, input logic [7:0] pre,
    input logic [23:0] smp, input logic [2:0] cuv, input logic full);
    int o;
    logic ok;
    logic [7:0] p;
    logic [31:0] w;
    o = s * 64;
    ok = 1'b1;
    w = 32'h0;
    for (int i = 0; i < 8; i++)
      p[7 - i] = hc[o + i] ^ ((s == 0) ? 1'b0 : hc[o - 1]);
    for (int i = 4; i < 32; i++)
    begin
      ok &= (hc[o + 2 * i] != hc[o + 2 * i - 1]);
      w[i] = hc[o + 2 * i] != hc[o + 2 * i + 1];
    end
    chk("preamble", pre, p);
    chk("cell edges", 1, ok);
    if (full)
      chk("subframe", {^{cuv, smp}, cuv, smp, 4'h0}, w);
  endtask : sub_check

  // Response watcher: oldest note off the queue at each completed transfer
  always @(posedge pclk)
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1)
      chk("apb response", expq.pop_front(),
        {pslverr, pwrite ? 32'h0 : prdata});

  initial
  begin
    pclk = 1'b0;
    forever
      #20 pclk = ~pclk;
  end

  // Watchdog: the whole sequence needs about 1 ms
  initial
  begin
    #2000000;
    mismatches++;
    conclude();
  end

  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {vpin, upin, strap, ratio, pol, rj} = '0;
    {sl, sr, al, ar} = '0;
    seed = 32'h632B;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, bat_pkg::A_CTRL, 0, {19'h0, bat_pkg::CTRL_RST});
    apb(0, 8'h10, 0, {1'b1, 32'h0});
    apb(1, 8'h14, 32'hFFFFFFFF, {1'b1, 32'h0});
    for (int i = 0; i < 5; i++)
    begin
      c = cfg[i];
      m = c[11:10];
      apb(1, bat_pkg::A_CTRL, 0, 0);
      repeat (20) @(posedge pclk);
      quiet(300);
      r = rnd();
      apb(1, bat_pkg::A_CS_LO, r, 0);
      apb(0, bat_pkg::A_CS_LO, 0, {1'b0, r});
      apb(1, bat_pkg::A_CS_HI, r, 0);
      apb(0, bat_pkg::A_CS_HI, 0, {17'h0, r[15:0]});
      ratio <= c[bat_pkg::CT_CKSEL];
      pol <= c[bat_pkg::CT_LRP];
      rj <= c[bat_pkg::CT_DFS];
      sl <= rnd();
      sr <= rnd();
      al <= rnd();
      ar <= rnd();
      // Flag pins stay put for whole frames, equal in both slots
      vpin <= (i == 2) ? 1'b0 : seed[3];
      upin <= seed[5];
      repeat (1200) @(posedge pclk);
      apb(1, bat_pkg::A_CTRL, c, 0);
      apb(0, bat_pkg::A_CTRL, 0, {19'h0, c});
      grab((m == 2'h1 || m == 2'h2) ? 2 : 1);
      el = c[bat_pkg::CT_SRC] ? al : sl;
      er = c[bat_pkg::CT_SRC] ? ar : sr;
      if (m == bat_pkg::MONO_LEFT)
        er = el;
      if (m == bat_pkg::MONO_RIGHT)
        el = er;
      v = c[bat_pkg::CT_VALIDITY_PIN_ENABLE] ? vpin
        : (c[bat_pkg::CT_VALIDITY_HOST_WRITE_MODE] & c[bat_pkg::CT_VHOST]);
      u = c[bat_pkg::CT_USER_BIT_PIN_ENABLE] & upin;
      sub_check(0, bat_pkg::PRE_B, 0, 0, 0);
      sub_check(1, bat_pkg::PRE_W, 0, 0, 0);
      sub_check(2, bat_pkg::PRE_M, el, {r[1], u, v}, 1);
      sub_check(3, bat_pkg::PRE_W, er, {r[1], u, v}, 1);
      chk("block sync", {c[13:12] == bat_pkg::PBS_TX, 1'b0},
        {hs[64], hs[192]});
      n = 0;
      for (int j = 0; j < 256; j++)
        n += (hl[j] !== (c[bat_pkg::CT_SRC] ? hc[j] : 1'b0));
      chk("loopback", 0, n);
      apb(1, bat_pkg::A_CTRL, c | 14'h0002, 0);
      repeat (20) @(posedge pclk);
      quiet(300);
    end
    // Strap pulled high: the transmitter must never start
    strap <= 1'b1;
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (10) @(posedge pclk);
    apb(1, bat_pkg::A_CTRL, 32'h1, 0);
    quiet(1500);
    // Stopped, strap refused, master clock still toggling, frame count zero
    apb(0, bat_pkg::A_STAT, 0, {1'b0, 32'h1 << bat_pkg::ST_MCK});
    conclude();
  end
endmodule : biphase_audio_transmitter_test
`default_nettype wire
